// [rtl/stg_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides
module stg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  always_comb begin
    in_ready    = (count != (AW+1)'(DEPTH));
    out_valid   = (count != '0);
    out_data    = mem[rd_ptr];
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage carries no reset; only the pointers and count define what is valid
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule : stg_fifo

// [rtl/stg_gen.sv]
// Serial link test-pattern generator: frame-wide octet source for both links
module stg_gen (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                link_enable,
  input  wire logic [3:0]          test_pattern_select,
  input  wire logic [1:0]          link_mode_select,
  input  wire logic                sync_req_n,
  input  wire logic [63:0]         conv_data_a,
  input  wire logic [63:0]         conv_data_b,
  input  wire logic                tx_ready,
  output stg_pkg::stg_frame_s      tx_a,
  output stg_pkg::stg_frame_s      tx_b,
  output logic                     tx_valid,
  output logic                     lane_en_a,
  output logic                     lane_en_b
);

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================================
  // Configuration decode
  // ==========================================================================
  stg_pkg::stg_cfg_s cfg;
  logic [7:0]        ms;
  logic [7:0]        pat_len;
  logic [15:0]       mid_val;

  always_comb begin
    cfg     = stg_pkg::mode_cfg(link_mode_select);
    ms      = 8'(cfg.m * cfg.s);
    pat_len = 8'((ms + 8'h02 + stg_pkg::K_FRAMES - 8'h01) / stg_pkg::K_FRAMES
                 * stg_pkg::K_FRAMES);
    mid_val = 16'h0001 << (cfg.n - 5'h01);
  end

  // ==========================================================================
  // Frame builders
  // ==========================================================================
  // One long transport frame; sample j belongs to converter j/S, sample j%S
  function automatic stg_pkg::stg_frame_s long_frame(input stg_pkg::stg_cfg_s c,
                                                     input logic [7:0] m_s,
                                                     input logic [15:0] mid,
                                                     input logic [7:0] fi);
    stg_pkg::stg_frame_s f;
    logic [15:0]         v;
    logic [3:0]          converter_index;
    logic [3:0]          sample_index;
    f = '0;
    for (int j = 0; j < stg_pkg::SAMPLES; j++) begin
      converter_index = (c.s == 4'h2) ? 4'(j >> 1) : 4'(j);
      sample_index    = (c.s == 4'h2) ? 4'(j & 1) : 4'h0;
      if (fi == 8'h00) begin
        v = 16'(converter_index) + 16'h0001;
      end else if (fi == 8'h01) begin
        v = 16'(sample_index) + 16'h0001;
      end else begin
        v = mid;
      end
      if (c.cs) begin
        // Sample sits above its control bit; bit j walks one frame at a time
        v = {v[14:0], (fi < m_s) && (fi == 8'(j))};
      end
      if (8'(j) < m_s) begin
        f.data[stg_pkg::SAMPLE_W*j +: stg_pkg::SAMPLE_W] = v;
      end
    end
    return f;
  endfunction : long_frame

  function automatic stg_pkg::stg_frame_s fill_frame(input logic [7:0] octet,
                                                     input logic k);
    stg_pkg::stg_frame_s f;
    f.data = {stg_pkg::OCTETS{octet}};
    f.k    = {stg_pkg::OCTETS{k}};
    return f;
  endfunction : fill_frame

  // Eight consecutive octets of the jitter sequence, starting at position p
  function automatic stg_pkg::stg_frame_s rpat_frame(input logic [3:0] p);
    stg_pkg::stg_frame_s f;
    f = '0;
    for (int o = 0; o < stg_pkg::OCTETS; o++) begin
      f.data[8*o +: 8] = stg_pkg::RPAT[(32'(p) + o) % stg_pkg::RPAT_LEN];
    end
    return f;
  endfunction : rpat_frame

  // Alignment frame: ramp payload, multiframe start and end markers
  function automatic stg_pkg::stg_frame_s ilas_frame(input logic [7:0] fi);
    stg_pkg::stg_frame_s f;
    f = '0;
    for (int o = 0; o < stg_pkg::OCTETS; o++) begin
      f.data[8*o +: 8] = fi + 8'(o);
    end
    if ((fi % stg_pkg::K_FRAMES) == 8'h00) begin
      f.data[7:0] = stg_pkg::CHR_K28_0;
      f.k[0]      = 1'b1;
    end
    if ((fi % stg_pkg::K_FRAMES) == stg_pkg::K_FRAMES - 8'h01) begin
      f.data[63:56] = stg_pkg::CHR_K28_3;
      f.k[7]        = 1'b1;
    end
    return f;
  endfunction : ilas_frame

  // ==========================================================================
  // Link sequencer
  // ==========================================================================
  stg_pkg::stg_state_e state;
  stg_pkg::stg_state_e next_state;
  logic [7:0]          fidx;
  logic [7:0]          next_fidx;
  logic [3:0]          rpat_idx;
  logic [3:0]          next_rpat_idx;
  logic                fifo_in_ready;
  logic                fire;
  stg_pkg::stg_frame_s gen_a;
  stg_pkg::stg_frame_s gen_b;
  logic                live_data;

  always_comb begin
    fire          = fifo_in_ready && link_enable;
    next_state    = state;
    next_fidx     = fidx;
    next_rpat_idx = rpat_idx;
    gen_a         = '0;
    gen_b         = '0;
    live_data     = 1'b0;
    // Free-running character modes bypass the link sequence
    case (test_pattern_select)
      stg_pkg::TP_D21_5: begin
        gen_a = fill_frame(stg_pkg::CHR_D21_5, 1'b0);
      end
      stg_pkg::TP_K28_5: begin
        gen_a = fill_frame(stg_pkg::CHR_K28_5, 1'b1);
      end
      stg_pkg::TP_RPAT: begin
        // Octets stay data characters so the encoder shapes them
        gen_a = rpat_frame(rpat_idx);
        next_rpat_idx = (rpat_idx >= 4'h4) ? rpat_idx - 4'h4 : rpat_idx + 4'h8;
      end
      default: begin
        case (state)
          stg_pkg::ST_CGS: begin
            gen_a = fill_frame(stg_pkg::CHR_K28_5, 1'b1);
            if (sync_req_n) begin
              next_state = stg_pkg::ST_ILAS;
              next_fidx  = 8'h00;
            end
          end
          stg_pkg::ST_ILAS: begin
            gen_a     = ilas_frame(fidx);
            next_fidx = fidx + 8'h01;
            if (fidx == stg_pkg::ILAS_FRAMES - 8'h01) begin
              next_fidx = 8'h00;
              if (test_pattern_select != stg_pkg::TP_ILAS) begin
                next_state = stg_pkg::ST_DATA;
              end
            end
          end
          stg_pkg::ST_DATA: begin
            if (test_pattern_select == stg_pkg::TP_LONG &&
                cfg.nprime == 5'(stg_pkg::NPRIME_LONG)) begin
              gen_a     = long_frame(cfg, ms, mid_val, fidx);
              next_fidx = (fidx == pat_len - 8'h01) ? 8'h00 : fidx + 8'h01;
            end else begin
              live_data  = 1'b1;
              gen_a.data = conv_data_a;
              gen_b.data = conv_data_b;
            end
          end
          default: begin
            next_state = stg_pkg::ST_CGS;
          end
        endcase
        if (!sync_req_n) begin
          next_state = stg_pkg::ST_CGS;
          next_fidx  = 8'h00;
        end
      end
    endcase
    // Test content is common to both links; only live data differs
    if (!live_data) begin
      gen_b = gen_a;
    end
    if (!fire) begin
      next_state    = state;
      next_fidx     = fidx;
      next_rpat_idx = rpat_idx;
    end
    if (!link_enable) begin
      // Restart point for a selection changed while the link is down
      next_state    = stg_pkg::ST_CGS;
      next_fidx     = 8'h00;
      next_rpat_idx = 4'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= stg_pkg::ST_CGS;
      fidx     <= 8'h00;
      rpat_idx <= 4'h0;
    end else begin
      state    <= next_state;
      fidx     <= next_fidx;
      rpat_idx <= next_rpat_idx;
    end
  end

  // ==========================================================================
  // Frame buffer and output stage
  // ==========================================================================
  localparam int FW = 2 * $bits(stg_pkg::stg_frame_s);

  logic          fifo_out_valid;
  logic          fifo_out_ready;
  logic [FW-1:0] fifo_out_data;
  logic          next_tx_valid;
  stg_pkg::stg_frame_s next_tx_a;
  stg_pkg::stg_frame_s next_tx_b;
  logic          next_lane_en_a;
  logic          next_lane_en_b;

  stg_fifo #(
    .WIDTH (FW),
    .DEPTH (4)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (link_enable),
    .in_ready  (fifo_in_ready),
    .in_data   ({gen_a, gen_b}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  always_comb begin
    // Output register refills whenever it is empty or being taken
    fifo_out_ready = !tx_valid || tx_ready;
    next_tx_valid  = tx_valid;
    next_tx_a      = tx_a;
    next_tx_b      = tx_b;
    if (fifo_out_ready) begin
      next_tx_valid = fifo_out_valid;
      if (fifo_out_valid) begin
        {next_tx_a, next_tx_b} = fifo_out_data;
      end
    end
    // Lanes power by link mode alone, whatever test mode is chosen
    next_lane_en_a = 1'b1;
    next_lane_en_b = !cfg.single;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid  <= 1'b0;
      tx_a      <= '0;
      tx_b      <= '0;
      lane_en_a <= 1'b0;
      lane_en_b <= 1'b0;
    end else begin
      tx_valid  <= next_tx_valid;
      tx_a      <= next_tx_a;
      tx_b      <= next_tx_b;
      lane_en_a <= next_lane_en_a;
      lane_en_b <= next_lane_en_b;
    end
  end

endmodule : stg_gen

// [rtl/stg_pkg.sv]
// Shared constants, configuration types and frame carrier for the test-pattern generator
package stg_pkg;

  // ==========================================================================
  // Frame geometry
  // ==========================================================================
  localparam int          OCTETS       = 8;
  localparam int          SAMPLES      = 4;
  localparam int          SAMPLE_W     = 16;
  localparam int          NPRIME_LONG  = 16;
  localparam logic [7:0]  K_FRAMES     = 8'h0a;
  localparam logic [7:0]  ILAS_MF      = 8'h04;
  localparam logic [7:0]  ILAS_FRAMES  = 8'h28;

  // ==========================================================================
  // Characters
  // ==========================================================================
  localparam logic [7:0]  CHR_K28_5    = 8'hbc;
  localparam logic [7:0]  CHR_K28_0    = 8'h1c;
  localparam logic [7:0]  CHR_K28_3    = 8'h7c;
  localparam logic [7:0]  CHR_D21_5    = 8'hb5;
  localparam int          RPAT_LEN     = 12;
  localparam logic [3:0]  RPAT_LAST    = 4'hb;
  localparam logic [7:0]  RPAT [RPAT_LEN] = '{8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f,
                                             8'hb3, 8'h14, 8'h5e, 8'hfb, 8'h35, 8'h59};

  // ==========================================================================
  // Selections
  // ==========================================================================
  localparam logic [3:0]  TP_NONE      = 4'h0;
  localparam logic [3:0]  TP_LONG      = 4'h1;
  localparam logic [3:0]  TP_D21_5     = 4'h2;
  localparam logic [3:0]  TP_K28_5     = 4'h3;
  localparam logic [3:0]  TP_ILAS      = 4'h4;
  localparam logic [3:0]  TP_RPAT      = 4'h5;

  localparam logic [1:0]  LM_DUAL_S1   = 2'h0;
  localparam logic [1:0]  LM_DUAL_S2   = 2'h1;
  localparam logic [1:0]  LM_SINGLE    = 2'h2;
  localparam logic [1:0]  LM_NARROW    = 2'h3;

  typedef enum logic [2:0] {
    ST_CGS  = 3'b001,
    ST_ILAS = 3'b010,
    ST_DATA = 3'b100
  } stg_state_e;

  typedef struct packed {
    logic [3:0] m;
    logic [3:0] s;
    logic [4:0] n;
    logic       cs;
    logic [4:0] nprime;
    logic       single;
  } stg_cfg_s;

  typedef struct packed {
    logic [OCTETS*8-1:0] data;
    logic [OCTETS-1:0]   k;
  } stg_frame_s;

  // Link configuration decoded from the link mode selection
  function automatic stg_cfg_s mode_cfg(input logic [1:0] sel);
    stg_cfg_s c;
    c = '{m: 4'h2, s: 4'h1, n: 5'h10, cs: 1'b0, nprime: 5'h10, single: 1'b0};
    case (sel)
      LM_DUAL_S2: c = '{m: 4'h2, s: 4'h2, n: 5'h0f, cs: 1'b1, nprime: 5'h10, single: 1'b0};
      LM_SINGLE:  c = '{m: 4'h4, s: 4'h1, n: 5'h10, cs: 1'b0, nprime: 5'h10, single: 1'b1};
      LM_NARROW:  c = '{m: 4'h2, s: 4'h1, n: 5'h0c, cs: 1'b0, nprime: 5'h0c, single: 1'b0};
      default:    c = '{m: 4'h2, s: 4'h1, n: 5'h10, cs: 1'b0, nprime: 5'h10, single: 1'b0};
    endcase
    return c;
  endfunction : mode_cfg

endpackage : stg_pkg

// [tb/stg_gen_chk.sv]
// Assertion checker for the test-pattern generator ports
module stg_gen_chk (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 link_enable,
  input  wire logic [3:0]           test_pattern_select,
  input  wire logic [1:0]           link_mode_select,
  input  wire logic                 sync_req_n,
  input  wire logic                 tx_ready,
  input  wire stg_pkg::stg_frame_s  tx_a,
  input  wire stg_pkg::stg_frame_s  tx_b,
  input  wire logic                 tx_valid,
  input  wire logic                 lane_en_a,
  input  wire logic                 lane_en_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Edges since reset release, saturating
  // ==========================================================================
  logic [2:0] rcnt;
  logic [2:0] next_rcnt;
  always_comb begin
    next_rcnt = (rcnt == 3'h7) ? rcnt : rcnt + 3'h1;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rcnt <= 3'h0;
    end else begin
      rcnt <= next_rcnt;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================================
  // Properties
  // ==========================================================================
  a_first_valid: assert property (rcnt < 3'h4 |-> !tx_valid)
    else $error("frame offered before reset settled");
  a_lane_follow: assert property (rcnt >= 3'h4 && $stable(link_mode_select) |-> lane_en_a
    && (lane_en_b == (link_mode_select != stg_pkg::LM_SINGLE)))
    else $error("lane enables do not follow link mode");
  a_stall_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_a)
    && $stable(tx_b))
    else $error("refused frame changed or vanished");
  a_flow_steady: assert property ((rcnt >= 3'h4 && link_enable && tx_ready) [*4] |=> tx_valid)
    else $error("running link stopped offering frames");
  a_d21_stream: assert property (tx_valid && test_pattern_select == stg_pkg::TP_D21_5
    |-> tx_a == {{8{8'hb5}}, 8'h00})
    else $error("wrong character in alternating mode");
  a_k28_stream: assert property (tx_valid && test_pattern_select == stg_pkg::TP_K28_5
    |-> tx_a == {{8{8'hbc}}, 8'hff})
    else $error("wrong character in comma mode");
  a_rpat_plain: assert property (tx_valid && test_pattern_select == stg_pkg::TP_RPAT
    |-> tx_a.k == 8'h00)
    else $error("control flag in jitter pattern");
  a_links_equal: assert property (tx_valid && test_pattern_select != stg_pkg::TP_NONE
    && link_mode_select != stg_pkg::LM_NARROW |-> tx_a == tx_b)
    else $error("links differ in test mode");
  c_stall: cover property (tx_valid && !tx_ready);
  c_resync: cover property (tx_valid && test_pattern_select == stg_pkg::TP_ILAS && !sync_req_n);
  c_single: cover property (tx_valid && lane_en_a && !lane_en_b);
endmodule : stg_gen_chk

bind stg_gen stg_gen_chk u_chk (.clk, .reset_n, .link_enable, .test_pattern_select,
  .link_mode_select, .sync_req_n, .tx_ready, .tx_a, .tx_b, .tx_valid, .lane_en_a, .lane_en_b);

// [tb/stg_gen_tb.sv]
// Self-checking bench for the test-pattern generator
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module stg_gen_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, link_enable, tx_ready, sync_req_n, slow, resync, tx_valid;
  logic lane_en_a, lane_en_b;
  logic [3:0]          test_pattern_select;
  logic [1:0]          link_mode_select;
  logic [63:0]         conv_data_a, conv_data_b;
  stg_pkg::stg_frame_s tx_a, tx_b;
  stg_pkg::stg_frame_s qa[$], qb[$];
  int                  fails = 0;
  int                  check_count = 0;
  stg_gen u_dut (.*);
  stg_rx_model u_rx (.clk, .slow, .resync, .tx_ready, .sync_req_n);
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      qa.push_back(tx_a);
      qb.push_back(tx_b);
    end
  end
  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic conclude;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic pop(output stg_pkg::stg_frame_s a, output stg_pkg::stg_frame_s b);
    for (int i = 0; i < 400 && qa.size() == 0; i++) begin
      @(negedge clk);
    end
    if (qa.size() == 0) begin
      fails++;
      conclude();
    end else begin
      a = qa.pop_front();
      b = qb.pop_front();
    end
  endtask : pop
  task automatic skip(input int n);
    stg_pkg::stg_frame_s a, b;
    for (int i = 0; i < n; i++) begin
      pop(a, b);
    end
  endtask : skip
  // Selection only changes with the link stopped and drained
  task automatic start(input logic [3:0] t, input logic [1:0] m);
    @(posedge clk);
    link_enable <= 1'b0;
    slow <= 1'b0;
    repeat (12) @(posedge clk);
    qa.delete();
    qb.delete();
    test_pattern_select <= t;
    link_mode_select <= m;
    @(posedge clk);
    link_enable <= 1'b1;
  endtask : start
  function automatic logic [63:0] lw(int f, int m, int s, int n, bit cs);
    logic [63:0] d;
    logic [15:0] v;
    d = 64'h0;
    for (int j = 0; j < m * s; j++) begin
      v = (f == 0) ? 16'(j / s + 1) : (f == 1) ? 16'(j % s + 1) : 16'(1 << (n - 1));
      d[16*j +: 16] = cs ? {v[14:0], 1'(f == j)} : v;
    end
    return d;
  endfunction : lw
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_chars;
    stg_pkg::stg_frame_s a, b;
    start(stg_pkg::TP_D21_5, stg_pkg::LM_DUAL_S1);
    skip(5);
    pop(a, b);
    `CHK(a, {{8{8'hb5}}, 8'h00})
    start(stg_pkg::TP_K28_5, stg_pkg::LM_SINGLE);
    skip(5);
    pop(a, b);
    `CHK(a, {{8{8'hbc}}, 8'hff})
  endtask : t_chars
  task automatic t_rpat;
    stg_pkg::stg_frame_s a, b;
    logic [7:0] tbl [12] = '{8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f,
                             8'hb3, 8'h14, 8'h5e, 8'hfb, 8'h35, 8'h59};
    start(stg_pkg::TP_RPAT, stg_pkg::LM_DUAL_S1);
    slow <= 1'b1;
    for (int f = 0; f < 6; f++) begin
      pop(a, b);
      for (int o = 0; o < 8; o++) begin
        `CHK(a.data[8*o +: 8], tbl[(8 * f + o) % 12])
      end
      `CHK(a.k, 8'h00)
    end
  endtask : t_rpat
  task automatic t_long(input logic [1:0] m, input int mm, input int s, input int n, input bit cs);
    stg_pkg::stg_frame_s a, b;
    start(stg_pkg::TP_LONG, m);
    slow <= (m == stg_pkg::LM_DUAL_S1);
    skip(41);
    for (int f = 0; f < 21; f++) begin
      pop(a, b);
      `CHK(a, {lw(f % 10, mm, s, n, cs), 8'h00})
      `CHK(b, a)
    end
    `CHK(lane_en_b, (m != stg_pkg::LM_SINGLE))
    `CHK(lane_en_a, 1'b1)
  endtask : t_long
  task automatic t_ilas;
    stg_pkg::stg_frame_s a, b;
    int i;
    start(stg_pkg::TP_ILAS, stg_pkg::LM_DUAL_S1);
    skip(41);
    pop(a, b);
    `CHK({a.data[7:0], a.k}, 16'h1c01)
    @(posedge clk);
    resync <= 1'b1;
    @(posedge clk);
    resync <= 1'b0;
    for (i = 0; i < 60 && a.k !== 8'hff; i++) begin
      pop(a, b);
    end
    `CHK(a, {{8{8'hbc}}, 8'hff})
    for (i = 0; i < 20 && a.k === 8'hff; i++) begin
      pop(a, b);
    end
    `CHK({a.data[7:0], a.k}, 16'h1c01)
  endtask : t_ilas
  // Live data: no test mode, or long pattern asked for where N' is not sixteen
  task automatic t_none(input logic [3:0] t, input logic [1:0] m);
    stg_pkg::stg_frame_s a, b;
    conv_data_a <= 64'h0123456789abcdef;
    conv_data_b <= 64'hfedcba9876543210;
    start(t, m);
    skip(41);
    pop(a, b);
    `CHK(a, {64'h0123456789abcdef, 8'h00})
    `CHK(b, {64'hfedcba9876543210, 8'h00})
  endtask : t_none
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    reset_n = 1'b0;
    link_enable = 1'b0;
    test_pattern_select = 4'h0;
    link_mode_select = 2'h0;
    conv_data_a = 64'h0;
    conv_data_b = 64'h0;
    slow = 1'b0;
    resync = 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_chars();
    t_rpat();
    t_long(stg_pkg::LM_DUAL_S1, 2, 1, 16, 1'b0);
    t_long(stg_pkg::LM_DUAL_S2, 2, 2, 15, 1'b1);
    t_long(stg_pkg::LM_SINGLE, 4, 1, 16, 1'b0);
    t_ilas();
    t_none(stg_pkg::TP_NONE, stg_pkg::LM_DUAL_S1);
    t_none(stg_pkg::TP_LONG, stg_pkg::LM_NARROW);
    conclude();
  end
endmodule : stg_gen_tb

// [tb/stg_rx_model.sv]
// Receiver stand-in: flow control and synchronisation requests
module stg_rx_model (
  input  wire logic clk,
  input  wire logic slow,
  input  wire logic resync,
  output logic      tx_ready,
  output logic      sync_req_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase = 2'h0;
  logic [2:0] hold = 3'h0;
  initial begin
    tx_ready = 1'b1;
    sync_req_n = 1'b1;
  end
  always @(posedge clk) begin
    phase <= phase + 2'h1;
    // Slow receiver takes one frame in four, so the buffer backs up
    tx_ready <= !slow || (phase == 2'h3);
    if (resync) begin
      hold <= 3'h4;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
    sync_req_n <= (hold == 3'h0) && !resync;
  end
endmodule : stg_rx_model
